// [hw/gals_defs.vh]
// Constants for the general pin alternate-function and lane strap block
// Contract
// - Pin 0 in alternate role feeds the auxiliary SPI data input.
// - Pin 1 in alternate role is driven as auxiliary SPI clock.
// - Pin 2 in alternate role is driven as auxiliary SPI data out.
// - Pin 3 in alternate role is active-low SPI chip select 0.
// - Pin 4 in ALT2 role is active-low SPI chip select 1.
// - Pin 4 as shutter output: high for left eye, low for right.
// - Pins 1 and 2 sampled at boot for lane count; board pulls them.
// - After boot pins 1 and 2 are free; latched count unaffected.
// - After reset every pin defaults to input direction.
// - Each pin: input, output, bidirectional, open-drain or alternate.
`ifndef GALS_DEFS_VH
`define GALS_DEFS_VH

// Per-pin mode codes, three bits each
`define GALS_MODE_W        3
`define GALS_MODE_IN       3'h0
`define GALS_MODE_OUT      3'h1
`define GALS_MODE_BIDIR    3'h2
`define GALS_MODE_ODRAIN   3'h3
`define GALS_MODE_ALT1     3'h4
`define GALS_MODE_ALT2     3'h5
`define GALS_MODE_RESET    3'h0

// Pin positions
`define GALS_PIN_DIN       0
`define GALS_PIN_SCLK      1
`define GALS_PIN_DOUT      2
`define GALS_PIN_CS0       3
`define GALS_PIN_CS1       4
`define GALS_NUM_PINS      6

// Strap bit positions inside the pin vector
`define GALS_STRAP_LO      1
`define GALS_STRAP_HI      2

`endif

// [hw/gals_pin_cell.v]
// One general pin cell: direction and drive for a chosen mode
`include "gals_defs.vh"
`default_nettype none

module gals_pin_cell
(
    input  wire [2:0] i_mode,
    input  wire       i_sw_out,
    input  wire       i_alt_val,
    output reg        o_pin_out,
    output reg        o_pin_oe
);

    always @*
    begin
        o_pin_out = 1'b0;
        o_pin_oe  = 1'b0;
        case (i_mode)
            `GALS_MODE_IN:
            begin
                o_pin_out = 1'b0;
                o_pin_oe  = 1'b0;
            end
            `GALS_MODE_OUT,
            `GALS_MODE_BIDIR:
            begin
                o_pin_out = i_sw_out;
                o_pin_oe  = 1'b1;
            end
            `GALS_MODE_ODRAIN:
            begin
                // Only pull low; external pullup makes the high
                o_pin_out = 1'b0;
                o_pin_oe  = ~i_sw_out;
            end
            `GALS_MODE_ALT1,
            `GALS_MODE_ALT2:
            begin
                o_pin_out = i_alt_val;
                o_pin_oe  = 1'b1;
            end
            default:
            begin
                o_pin_out = 1'b0;
                o_pin_oe  = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// [hw/gals_top.v]
// General pin mux with auxiliary SPI roles, shutter output and lane strap
`include "gals_defs.vh"
`default_nettype none

module gals_top
#(
    parameter NPIN = `GALS_NUM_PINS
)
(
    input  wire                        i_clk_sys,
    input  wire                        i_rstn,
    // Per-pin mode, packed three bits per pin
    input  wire [NPIN*`GALS_MODE_W-1:0] i_pin_mode,
    input  wire [NPIN-1:0]             i_sw_out,
    output reg  [NPIN-1:0]             o_sw_in,
    // Auxiliary SPI controller side
    input  wire                        i_aux_serial_clock,
    input  wire                        i_aux_serial_data_out,
    input  wire                        i_aux_xfer_active,
    input  wire                        i_aux_sel,
    output reg                         o_aux_serial_data_in,
    // Shutter: 1 = left eye
    input  wire                        i_shutter_left,
    // Pin side
    input  wire [NPIN-1:0]             i_pin_in,
    output wire [NPIN-1:0]             o_pin_out,
    output wire [NPIN-1:0]             o_pin_oe,
    // Lane strap result
    output reg  [2:0]                  o_lane_count,
    output reg  [1:0]                  o_lane_code,
    output reg                         o_strap_valid
);

    reg  [NPIN-1:0] alt_val;
    reg  [NPIN*`GALS_MODE_W-1:0] mode_eff;
    reg             boot_r;
    wire            sel0_n;
    wire            sel1_n;

    function [2:0] mode_of;
        input [NPIN*`GALS_MODE_W-1:0] vec;
        input integer                 idx;
        begin
            mode_of = vec[idx*`GALS_MODE_W +: `GALS_MODE_W];
        end
    endfunction

    function is_alt;
        input [2:0] m;
        begin
            is_alt = (m == `GALS_MODE_ALT1) || (m == `GALS_MODE_ALT2);
        end
    endfunction

    // Chip selects deasserted unless role chosen and transfer running
    assign sel0_n = ~(is_alt(mode_of(i_pin_mode, `GALS_PIN_CS0))
                      && i_aux_xfer_active && !i_aux_sel);
    assign sel1_n = ~((mode_of(i_pin_mode, `GALS_PIN_CS1)
                       == `GALS_MODE_ALT2)
                      && i_aux_xfer_active && i_aux_sel);

    // Alternate role values; pin 4 ALT1 is shutter, ALT2 is chip select 1
    always @*
    begin
        alt_val = {NPIN{1'b0}};
        alt_val[`GALS_PIN_SCLK] = i_aux_serial_clock;
        alt_val[`GALS_PIN_DOUT] = i_aux_serial_data_out;
        alt_val[`GALS_PIN_CS0]  = sel0_n;
        if (mode_of(i_pin_mode, `GALS_PIN_CS1) == `GALS_MODE_ALT1)
            alt_val[`GALS_PIN_CS1] = i_shutter_left;
        else
            alt_val[`GALS_PIN_CS1] = sel1_n;
    end

    // Pin 0 alternate role is an input; strap pins stay inputs in boot
    always @*
    begin
        mode_eff = i_pin_mode;
        if (is_alt(mode_of(i_pin_mode, `GALS_PIN_DIN)))
            mode_eff[`GALS_PIN_DIN*`GALS_MODE_W +: `GALS_MODE_W] =
                `GALS_MODE_IN;
        if (boot_r)
        begin
            mode_eff[`GALS_STRAP_LO*`GALS_MODE_W +: `GALS_MODE_W] =
                `GALS_MODE_IN;
            mode_eff[`GALS_STRAP_HI*`GALS_MODE_W +: `GALS_MODE_W] =
                `GALS_MODE_IN;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1)
        begin : g_cell
            gals_pin_cell u_cell
            (
                .i_mode    (boot_r ? `GALS_MODE_RESET :
                            mode_eff[g*`GALS_MODE_W +: `GALS_MODE_W]),
                .i_sw_out  (i_sw_out[g]),
                .i_alt_val (alt_val[g]),
                .o_pin_out (o_pin_out[g]),
                .o_pin_oe  (o_pin_oe[g])
            );
        end
    endgenerate

    // Input sampling for software and SPI data input
    always @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            o_sw_in              <= {NPIN{1'b0}};
            o_aux_serial_data_in <= 1'b0;
        end
        else
        begin
            o_sw_in              <= i_pin_in;
            o_aux_serial_data_in <= is_alt(mode_of(i_pin_mode,
                                    `GALS_PIN_DIN))
                                    & i_pin_in[`GALS_PIN_DIN];
        end
    end

    // Strap latch: boot_r set during reset, captured on first edge after
    always @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            boot_r        <= 1'b1;
            o_strap_valid <= 1'b0;
            o_lane_code   <= 2'h0;
            o_lane_count  <= 3'h0;
        end
        else if (boot_r)
        begin
            boot_r        <= 1'b0;
            o_strap_valid <= 1'b1;
            o_lane_code   <= {i_pin_in[`GALS_STRAP_HI],
                              i_pin_in[`GALS_STRAP_LO]};
            o_lane_count  <= {1'b0, i_pin_in[`GALS_STRAP_HI],
                              i_pin_in[`GALS_STRAP_LO]}
                             + 3'h1;
        end
    end

endmodule

`default_nettype wire

// [verif/gals_board.sv]
// Board model: strap pulls, select pull-ups, peripheral data
`default_nettype none
module gals_board (
    input  wire logic [5:0] i_oe,
    input  wire logic [5:0] i_drv,
    input  wire logic [1:0] i_strap,
    input  wire logic       i_miso,
    output logic      [5:0] o_pad
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pins fall to the board pull level
    assign o_pad = (i_oe & i_drv) | (~i_oe & {3'h3, i_strap, i_miso});
endmodule
`default_nettype wire

// [verif/gals_checker.sv]
// Port checker for the pin mux and lane strap block
`default_nettype none
module gals_checker #(parameter NPIN = 6) (
    input wire logic              i_clk_sys,
    input wire logic              i_rstn,
    input wire logic [NPIN*3-1:0] i_pin_mode,
    input wire logic              i_aux_serial_clock,
    input wire logic              i_aux_serial_data_out,
    input wire logic              i_aux_xfer_active,
    input wire logic              i_aux_sel,
    input wire logic              i_shutter_left,
    input wire logic [NPIN-1:0]   i_pin_in,
    input wire logic [NPIN-1:0]   o_pin_out,
    input wire logic [NPIN-1:0]   o_pin_oe,
    input wire logic              o_aux_serial_data_in,
    input wire logic [2:0]        o_lane_count,
    input wire logic [1:0]        o_lane_code,
    input wire logic              o_strap_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);
    sequence s_boot;
        !i_rstn ##1 i_rstn;
    endsequence
    a_strap_take: assert property (disable iff (1'b0)
        s_boot |=> o_strap_valid && o_lane_code == $past(i_pin_in[2:1])
        && o_lane_count == {1'b0, o_lane_code} + 3'h1) else $error("strap");
    a_strap_keep: assert property (o_strap_valid |=> o_strap_valid
        && $stable(o_lane_code) && $stable(o_lane_count)) else $error("keep");
    a_reset_input: assert property (disable iff (1'b0)
        !i_rstn |=> o_pin_oe == '0 && !o_strap_valid) else $error("reset");
    a_din_route: assert property (o_strap_valid
        && (i_pin_mode[2:0] == 3'h4 || i_pin_mode[2:0] == 3'h5)
        |-> !o_pin_oe[0] ##1 o_aux_serial_data_in == $past(i_pin_in[0]))
        else $error("din");
    a_sclk_route: assert property (o_strap_valid && i_pin_mode[5:3] == 3'h4
        |-> o_pin_oe[1] && o_pin_out[1] == i_aux_serial_clock) else $error("clk");
    a_dout_route: assert property (o_strap_valid && i_pin_mode[8:6] == 3'h4
        |-> o_pin_oe[2] && o_pin_out[2] == i_aux_serial_data_out) else $error("dout");
    a_select0_out: assert property (o_strap_valid && i_pin_mode[11:9] == 3'h4
        |-> o_pin_oe[3] && o_pin_out[3] == !(i_aux_xfer_active && !i_aux_sel))
        else $error("cs0");
    a_select1_out: assert property (o_strap_valid && i_pin_mode[14:12] == 3'h5
        |-> o_pin_oe[4] && o_pin_out[4] == !(i_aux_xfer_active && i_aux_sel))
        else $error("cs1");
    a_shutter_eye: assert property (o_strap_valid && i_pin_mode[14:12] == 3'h4
        |-> o_pin_oe[4] && o_pin_out[4] == i_shutter_left) else $error("eye");
endmodule
bind gals_top gals_checker #(.NPIN(NPIN)) u_chk (.*);
`default_nettype wire

// [verif/gals_top_test.sv]
// Self-checking bench for the pin mux and lane strap block
`default_nettype none
module gals_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk_sys = 0, i_rstn = 0, i_aux_serial_clock = 0;
    logic        i_aux_serial_data_out = 0, i_aux_xfer_active = 0;
    logic        i_aux_sel = 0, i_shutter_left = 0, miso = 0;
    logic        o_aux_serial_data_in, o_strap_valid;
    logic [17:0] i_pin_mode = '0;
    logic [5:0]  i_sw_out = '0, i_pin_in, o_sw_in, o_pin_out, o_pin_oe;
    logic [2:0]  o_lane_count;
    logic [1:0]  o_lane_code, strap = '0, e;
    int          mismatches = 0, checks = 0;
    gals_top u_dut (.*);
    gals_board u_brd (.i_oe(o_pin_oe), .i_drv(o_pin_out), .i_strap(strap),
                      .i_miso(miso), .o_pad(i_pin_in));
    initial forever #50 i_clk_sys = ~i_clk_sys;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic put(input int p, input logic [2:0] m);
        i_pin_mode[3*p+:3] = m;
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        for (int c = 0; c < 4; c++)
        begin
            strap = c[1:0];
            i_rstn = 0;
            tick(8);
            chk(o_pin_oe, 8'h00);
            i_rstn = 1;
            tick(1);
            chk({o_strap_valid, o_lane_count, o_lane_code},
                {1'b1, 3'(c + 1), c[1:0]});
            put(1, 3'h1);
            put(2, 3'h1);
            i_sw_out = {3'h0, ~c[1:0], 1'b0};
            tick(2);
            chk(o_lane_code, c[1:0]);
            $display("strap test %0d done", c);
        end
        // Unused pin 5 set as an output driven from i_sw_out[5]
        put(5, 3'h1);
        i_pin_mode = {3'h1, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4};
        for (int k = 0; k < 16; k++)
        begin
            {i_aux_xfer_active, i_aux_sel} = k[3:2];
            {i_aux_serial_clock, i_aux_serial_data_out} = k[1:0];
            miso = k[0];
            i_sw_out = {k[1], 5'h00};
            tick(1);
            chk(o_pin_oe, 8'h3e);
            chk(o_pin_out[2:1], {k[0], k[1]});
            chk(o_pin_out[3], !(k[3] && !k[2]));
            chk(o_pin_out[4], !(k[3] && k[2]));
            chk(o_pin_out[5], k[1]);
            chk(o_aux_serial_data_in, k[0]);
        end
        $display("aux serial test done");
        put(4, 3'h4);
        for (int m = 0; m < 8; m++)
        begin
            put(5, 3'(m / 2));
            i_shutter_left = m[0];
            i_sw_out[5] = m[0];
            e = (m < 2) ? 2'h0 : (m < 6) ? {1'b1, m[0]} : {!m[0], 1'b0};
            tick(1);
            chk(o_pin_out[4], m[0]);
            chk({o_pin_oe[5], o_pin_out[5] & o_pin_oe[5]}, e);
            chk(o_sw_in[5], e[0]);
        end
        $display("pin mode test done");
        give_verdict();
    end
endmodule
`default_nettype wire
